// file: pdw_edge_if.sv
// Interface that carries qualified pin edges from the synchroniser to the wakeup logic.
`timescale 1ns/1ps
interface pdw_edge_if;
    import pdw_pkg::*;

    logic [PDW_PORT_W-1:0] rise;
    logic [PDW_PORT_W-1:0] fall;

    modport src (output rise, output fall);
    modport dst (input rise, input fall);
endinterface

// file: pdw_pin_model.sv
// Behavioural model of the eight port B pins seen by the wakeup block.
`timescale 1ns/1ps
module pdw_pin_model
    import pdw_pkg::*;
(
    // Clock.
    input  wire logic                  clk_i,
    // Pin levels.
    output logic      [PDW_PORT_W-1:0] pins_o
);
    // Low pins idle high and high pins idle low, so each can make either edge.
    initial begin
        pins_o = 8'h0f;
    end
    // Flip one pin after a chosen delay; the level then stays put, since the
    // synchroniser needs it on two samples.
    task automatic flip(input int idx, input int delay);
        repeat (delay) @(posedge clk_i);
        pins_o[idx] <= ~pins_o[idx];
    endtask
endmodule

// file: pdw_pin_sync.sv
// Three-stage synchroniser and edge qualifier for the port B pins.
`timescale 1ns/1ps
module pdw_pin_sync
    import pdw_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    // Asynchronous pins.
    input  wire logic [PDW_PORT_W-1:0] pins_i,
    // Qualified edges.
    pdw_edge_if.src                    edge_o
);
    import pdw_pkg::*;

    typedef struct packed {
        logic [PDW_PORT_W-1:0] s1;
        logic [PDW_PORT_W-1:0] s2;
        logic [PDW_PORT_W-1:0] s3;
        logic [PDW_PORT_W-1:0] stable;
        logic [1:0]            prime;
        logic [PDW_PORT_W-1:0] rise;
        logic [PDW_PORT_W-1:0] fall;
    } pdw_sync_t;

    localparam pdw_sync_t SYNC_RST = '0;

    pdw_sync_t sync_r;
    pdw_sync_t sync_nxt;
    logic [PDW_PORT_W-1:0] agree;

    // A level counts only once stages two and three agree, so a change yields one edge.
    always_comb begin
        sync_nxt      = sync_r;
        agree         = ~(sync_r.s2 ^ sync_r.s3);
        sync_nxt.s1   = pins_i;
        sync_nxt.s2   = sync_r.s1;
        sync_nxt.s3   = sync_r.s2;
        sync_nxt.rise = '0;
        sync_nxt.fall = '0;
        if (sync_r.prime != PDW_PRIME_N) begin
            // The pins settle into the chain before any edge may be reported.
            // Stage two already holds what stage three shows next, so the settled
            // level starts at the pin level and reset makes no false edge.
            sync_nxt.prime  = sync_r.prime + 2'h1;
            sync_nxt.stable = sync_r.s2;
        end else begin
            sync_nxt.rise   = agree & sync_r.s3 & ~sync_r.stable;
            sync_nxt.fall   = agree & ~sync_r.s3 & sync_r.stable;
            sync_nxt.stable = (agree & sync_r.s3) | (~agree & sync_r.stable);
        end
    end

    // State register; the clock enable freezes everything.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_r <= SYNC_RST;
        end else if (ce_i) begin
            sync_r <= sync_nxt;
        end
    end

    assign edge_o.rise = sync_r.rise;
    assign edge_o.fall = sync_r.fall;
endmodule

// file: pdw_pkg.sv
// Shared constants and types of the power-down and multi-input wakeup block.
package pdw_pkg;

    // ************************************************************
    // Widths and vectors
    // ************************************************************
    localparam int          PDW_PORT_W    = 8;
    localparam int          PDW_PC_W      = 11;
    localparam int          PDW_SEL_W     = 8;
    localparam int          PDW_CTRL_W    = 3;
    localparam int          PDW_SYNC_N    = 3;
    localparam logic [10:0] PDW_RESET_PC  = 11'h7ff;

    // ************************************************************
    // Port-access selector codes and control locations
    // ************************************************************
    localparam logic [7:0]  PDW_SEL_PEND  = 8'h09;
    localparam logic [7:0]  PDW_SEL_EDGE  = 8'h0a;
    localparam logic [7:0]  PDW_SEL_EN    = 8'h0b;
    localparam logic [2:0]  PDW_CTRL_PORTB = 3'h6;

    // ************************************************************
    // Reset values and the synchroniser priming count
    // ************************************************************
    localparam logic [7:0]  PDW_EN_RST    = 8'hff;
    localparam logic [7:0]  PDW_EDGE_RST  = 8'hff;
    localparam logic [7:0]  PDW_PEND_RST  = 8'h00;
    localparam logic        PDW_TO_RST    = 1'b1;
    localparam logic        PDW_PD_RST    = 1'b1;
    localparam logic [1:0]  PDW_PRIME_N   = 2'h3;

    // ************************************************************
    // Power state machine, Gray coded along run, sleep, wake
    // ************************************************************
    typedef enum logic [1:0] {
        PDW_RUN   = 2'b00,
        PDW_SLEEP = 2'b01,
        PDW_WAKE  = 2'b11
    } pdw_state_t;

endpackage

// file: pdw_wakeup.sv
// Power-down control, watchdog and multi-input wakeup registers of the controller.
`timescale 1ns/1ps

module pdw_wakeup
    import pdw_pkg::*;
#(
    parameter int WDT_WIDTH = 16
)(
    // Clock, reset and enable.
    input  wire logic                   SYS_CLK_I,
    input  wire logic                   RST_I,
    input  wire logic                   CE_I,
    // Core instruction strobes.
    input  wire logic                   SLEEP_EXEC_I,
    input  wire logic                   WDT_ENABLE_I,
    input  wire logic                   WDT_CLEAR_I,
    // Control location write from the core.
    input  wire logic                   CTRL_WR_I,
    input  wire logic [PDW_CTRL_W-1:0]  CTRL_ADDR_I,
    input  wire logic [PDW_SEL_W-1:0]   PORT_SEL_I,
    input  wire logic [PDW_PORT_W-1:0]  W_DATA_I,
    // Working register return path.
    output logic      [PDW_PORT_W-1:0]  W_DATA_O,
    output logic                        W_LOAD_O,
    // Pins.
    input  wire logic [PDW_PORT_W-1:0]  PORT_B_PINS_I,
    input  wire logic                   EXTERNAL_RESET_PIN_N_I,
    // Power and status.
    output logic                        CORE_HALT_O,
    output logic                        TIMEOUT_FLAG_O,
    output logic                        POWERED_DOWN_FLAG_O,
    output logic                        WDT_OVERFLOW_O,
    output logic                        PORT_B_IRQ_O,
    output logic                        PC_LOAD_O,
    output logic      [PDW_PC_W-1:0]    PC_O,
    output logic      [PDW_PORT_W-1:0]  PENDING_O
);
    import pdw_pkg::*;

    // ************************************************************
    // Elaboration check
    // ************************************************************
    if (WDT_WIDTH < 2 || WDT_WIDTH > 30) begin : g_bad_wdt
        $error("WDT_WIDTH must lie between 2 and 30.");
    end

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        pdw_state_t              state;
        logic                    halt;
        logic [PDW_PORT_W-1:0]   en_n;
        logic [PDW_PORT_W-1:0]   edge_sel;
        logic [PDW_PORT_W-1:0]   pend;
        logic [WDT_WIDTH-1:0]    wdt;
        logic                    to_flag;
        logic                    pd_flag;
        logic                    wdt_ovf;
        logic                    irq;
        logic                    pc_load;
        logic [PDW_PORT_W-1:0]   wdata;
        logic                    wload;
        logic [PDW_SYNC_N-1:0]   ext_sync;
    } pdw_core_t;

    localparam pdw_core_t CORE_RST = '{
        state:    PDW_RUN,
        halt:     1'b0,
        en_n:     PDW_EN_RST,
        edge_sel: PDW_EDGE_RST,
        pend:     PDW_PEND_RST,
        wdt:      '0,
        to_flag:  PDW_TO_RST,
        pd_flag:  PDW_PD_RST,
        wdt_ovf:  1'b0,
        irq:      1'b0,
        pc_load:  1'b0,
        wdata:    '0,
        wload:    1'b0,
        ext_sync: '1
    };

    pdw_core_t core_r;
    pdw_core_t core_nxt;

    // ************************************************************
    // Edge synchroniser
    // ************************************************************
    pdw_edge_if edges ();

    pdw_pin_sync u_pin_sync (
        .clk_i  (SYS_CLK_I),
        .rst_i  (RST_I),
        .ce_i   (CE_I),
        .pins_i (PORT_B_PINS_I),
        .edge_o (edges)
    );

    // Decodes a port B control write with the given selector code.
    function automatic logic portb_wr(input logic wr, input logic [PDW_CTRL_W-1:0] addr,
                                      input logic [PDW_SEL_W-1:0] sel,
                                      input logic [PDW_SEL_W-1:0] code);
        portb_wr = wr && (addr == PDW_CTRL_PORTB) && (sel == code);
    endfunction

    logic [PDW_PORT_W-1:0] hit;
    logic [PDW_PORT_W-1:0] wake_hit;
    logic                  ext_rst;
    logic                  wdt_top;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        core_nxt = core_r;
        // Each pin picks the edge its select bit names.
        hit      = (edges.fall & core_r.edge_sel) | (edges.rise & ~core_r.edge_sel);
        wake_hit = hit & ~core_r.en_n;
        ext_rst  = ~core_r.ext_sync[PDW_SYNC_N-1] & ~core_r.ext_sync[PDW_SYNC_N-2];
        wdt_top  = &core_r.wdt;

        core_nxt.ext_sync = {core_r.ext_sync[PDW_SYNC_N-2:0], EXTERNAL_RESET_PIN_N_I};
        core_nxt.wdt_ovf  = 1'b0;
        core_nxt.irq      = 1'b0;
        core_nxt.pc_load  = 1'b0;
        core_nxt.wload    = 1'b0;

        // Watchdog keeps counting in every state while enabled.
        if (WDT_ENABLE_I) begin
            core_nxt.wdt = core_r.wdt + {{(WDT_WIDTH-1){1'b0}}, 1'b1};
        end
        if (WDT_CLEAR_I) begin
            core_nxt.wdt = '0;
        end
        if (WDT_ENABLE_I && wdt_top) begin
            core_nxt.wdt_ovf = 1'b1;
            core_nxt.to_flag = 1'b0;
        end

        // Register writes through the port B control location.
        if (portb_wr(CTRL_WR_I, CTRL_ADDR_I, PORT_SEL_I, PDW_SEL_EDGE)) begin
            core_nxt.edge_sel = W_DATA_I;
        end
        if (portb_wr(CTRL_WR_I, CTRL_ADDR_I, PORT_SEL_I, PDW_SEL_EN)) begin
            core_nxt.en_n = W_DATA_I;
        end

        // Pending: new edges win over a clearing write in the same cycle.
        if (portb_wr(CTRL_WR_I, CTRL_ADDR_I, PORT_SEL_I, PDW_SEL_PEND)) begin
            core_nxt.wdata = core_r.pend;
            core_nxt.wload = 1'b1;
            core_nxt.pend  = W_DATA_I | hit;
        end else begin
            core_nxt.pend  = core_r.pend | hit;
        end

        // Power state machine.
        case (core_r.state)
            PDW_RUN: begin
                core_nxt.irq = |wake_hit;
                if (SLEEP_EXEC_I) begin
                    core_nxt.state = PDW_SLEEP;
                    core_nxt.halt  = 1'b1;
                    if (WDT_ENABLE_I) begin
                        core_nxt.wdt     = '0;
                        core_nxt.to_flag = 1'b1;
                        core_nxt.pd_flag = 1'b0;
                    end
                end
            end
            PDW_SLEEP: begin
                // Only a watchdog overflow or an enabled edge ends the sleep here.
                if ((WDT_ENABLE_I && wdt_top) || (|wake_hit)) begin
                    core_nxt.state = PDW_WAKE;
                    core_nxt.halt  = 1'b0;
                end
            end
            PDW_WAKE: begin
                core_nxt.pc_load = 1'b1;
                core_nxt.state   = PDW_RUN;
            end
            default: begin
                core_nxt.state = PDW_RUN;
                core_nxt.halt  = 1'b0;
            end
        endcase

        // External reset pin reloads the core reset values, keeping its own synchroniser; the port B pin synchroniser is not reset.
        if (ext_rst) begin
            core_nxt          = CORE_RST;
            core_nxt.ext_sync = {core_r.ext_sync[PDW_SYNC_N-2:0], EXTERNAL_RESET_PIN_N_I};
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    // Pending gets a defined reset value so simulation stays clean; firmware
    // still has to clear it before enabling any pin.
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            core_r <= CORE_RST;
        end else if (CE_I) begin
            core_r <= core_nxt;
        end
    end

    // ************************************************************
    // Outputs, all but the constant PC_O straight from the state register
    // ************************************************************
    assign W_DATA_O            = core_r.wdata;
    assign W_LOAD_O            = core_r.wload;
    assign CORE_HALT_O         = core_r.halt;
    assign TIMEOUT_FLAG_O      = core_r.to_flag;
    assign POWERED_DOWN_FLAG_O = core_r.pd_flag;
    assign WDT_OVERFLOW_O      = core_r.wdt_ovf;
    assign PORT_B_IRQ_O        = core_r.irq;
    assign PC_LOAD_O           = core_r.pc_load;
    assign PC_O                = PDW_RESET_PC;
    assign PENDING_O           = core_r.pend;
endmodule

// file: pdw_wakeup_sva.sv
// Concurrent checks on the ports of the wakeup block.
`timescale 1ns/1ps
module pdw_wakeup_sva
    import pdw_pkg::*;
#(
    parameter int WDT_WIDTH = 16
)(
    // Clock, reset and core strobes.
    input wire logic                  SYS_CLK_I,
    input wire logic                  RST_I,
    input wire logic                  CE_I,
    input wire logic                  SLEEP_EXEC_I,
    input wire logic                  WDT_ENABLE_I,
    input wire logic                  CTRL_WR_I,
    input wire logic [PDW_CTRL_W-1:0] CTRL_ADDR_I,
    input wire logic [PDW_SEL_W-1:0]  PORT_SEL_I,
    input wire logic                  EXTERNAL_RESET_PIN_N_I,
    // Observed outputs.
    input wire logic [PDW_PORT_W-1:0] W_DATA_O,
    input wire logic                  W_LOAD_O,
    input wire logic                  CORE_HALT_O,
    input wire logic                  TIMEOUT_FLAG_O,
    input wire logic                  POWERED_DOWN_FLAG_O,
    input wire logic                  WDT_OVERFLOW_O,
    input wire logic                  PORT_B_IRQ_O,
    input wire logic                  PC_LOAD_O,
    input wire logic [PDW_PC_W-1:0]   PC_O,
    input wire logic [PDW_PORT_W-1:0] PENDING_O
);
    // A pending exchange; the pin reset counts as reset, since it reloads the core reset values.
    wire logic swap_w = CE_I && CTRL_WR_I && CTRL_ADDR_I == PDW_CTRL_PORTB
                        && PORT_SEL_I == PDW_SEL_PEND;
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I || !EXTERNAL_RESET_PIN_N_I);

    // ************************************************************
    // Assertions
    // ************************************************************
    // The cycle right after a wake is the wake state, where a sleep strobe is not taken.
    halt_on_sleep_a: assert property (
        SLEEP_EXEC_I && CE_I && !CORE_HALT_O && !$fell(CORE_HALT_O) |=> CORE_HALT_O)
        else $error("halt missing after sleep");
    halt_cause_a: assert property ($rose(CORE_HALT_O) |-> $past(SLEEP_EXEC_I))
        else $error("halt without sleep");
    sleep_flags_a: assert property (
        SLEEP_EXEC_I && WDT_ENABLE_I && CE_I && !CORE_HALT_O && !$fell(CORE_HALT_O)
        |=> TIMEOUT_FLAG_O && !POWERED_DOWN_FLAG_O) else $error("status flags wrong after sleep");
    wake_reset_pc_a: assert property (
        $fell(CORE_HALT_O) |=> PC_LOAD_O && PC_O == PDW_RESET_PC)
        else $error("no program counter load at wake");
    swap_return_a: assert property (
        swap_w |=> W_LOAD_O && W_DATA_O == $past(PENDING_O))
        else $error("exchange did not return old pending");
    no_swap_a: assert property (!swap_w |=> !W_LOAD_O)
        else $error("exchange on other access");
    pend_hold_a: assert property (
        !swap_w |=> (PENDING_O & $past(PENDING_O)) == $past(PENDING_O))
        else $error("pending bit lost without a write");
    irq_running_a: assert property (
        PORT_B_IRQ_O |-> !CORE_HALT_O && PENDING_O != 8'h00)
        else $error("interrupt without pending or while halted");
    wdt_spacing_a: assert property (WDT_OVERFLOW_O |=> !WDT_OVERFLOW_O [*8])
        else $error("watchdog overflow too soon");
    wdt_wake_a: assert property (WDT_OVERFLOW_O |-> ##[0:2] !CORE_HALT_O)
        else $error("watchdog overflow did not wake");

    // Main scenarios reached.
    cover property ($fell(CORE_HALT_O));
    cover property (swap_w);
    cover property (PORT_B_IRQ_O);
    cover property (WDT_OVERFLOW_O && CORE_HALT_O);
endmodule

bind pdw_wakeup pdw_wakeup_sva #(.WDT_WIDTH(WDT_WIDTH)) i_sva (.SYS_CLK_I, .RST_I, .CE_I,
    .SLEEP_EXEC_I, .WDT_ENABLE_I, .CTRL_WR_I, .CTRL_ADDR_I, .PORT_SEL_I, .EXTERNAL_RESET_PIN_N_I,
    .W_DATA_O, .W_LOAD_O, .CORE_HALT_O, .TIMEOUT_FLAG_O, .POWERED_DOWN_FLAG_O, .WDT_OVERFLOW_O,
    .PORT_B_IRQ_O, .PC_LOAD_O, .PC_O, .PENDING_O);

// file: power_down_multi_input_wakeup_bench.sv
// Self-checking testbench of the power-down and wakeup block.
`timescale 1ns/1ps
module power_down_multi_input_wakeup_bench;
    import pdw_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, sleep = 1'b0, ext_n = 1'b1;
    logic        wdt_en = 1'b0, wdt_clr = 1'b0, wr = 1'b0;
    logic [2:0]  addr = PDW_CTRL_PORTB;
    logic [7:0]  sel = 8'h00, wd = 8'h00, pins, w_o, pend;
    logic [10:0] pc;
    logic        w_ld, halt, to_f, pd_f, ovf, irq, pc_ld;
    int          n_mismatch = 0, total_checks = 0, n_irq = 0, n_pcld = 0, n_ovf = 0, base;
    localparam int WDT_W = 4;

    pdw_pin_model i_pins (.clk_i(clk), .pins_o(pins));
    // The short watchdog keeps the overflow wake within a few dozen cycles.
    pdw_wakeup #(.WDT_WIDTH(WDT_W)) i_dut (.SYS_CLK_I(clk), .RST_I(rst), .CE_I(ce),
        .SLEEP_EXEC_I(sleep), .WDT_ENABLE_I(wdt_en), .WDT_CLEAR_I(wdt_clr), .CTRL_WR_I(wr),
        .CTRL_ADDR_I(addr), .PORT_SEL_I(sel), .W_DATA_I(wd), .W_DATA_O(w_o), .W_LOAD_O(w_ld),
        .PORT_B_PINS_I(pins), .EXTERNAL_RESET_PIN_N_I(ext_n), .CORE_HALT_O(halt),
        .TIMEOUT_FLAG_O(to_f), .POWERED_DOWN_FLAG_O(pd_f), .WDT_OVERFLOW_O(ovf),
        .PORT_B_IRQ_O(irq), .PC_LOAD_O(pc_ld), .PC_O(pc), .PENDING_O(pend));

    // ************************************************************
    // Clock, pulse counters and shared tasks
    // ************************************************************
    initial begin
        forever #5 clk = ~clk;
    end
    // One-cycle pulses are counted here so no scenario can miss one.
    always @(posedge clk) begin
        if (irq === 1'b1) n_irq <= n_irq + 1;
        if (pc_ld === 1'b1) n_pcld <= n_pcld + 1;
        if (ovf === 1'b1) n_ovf <= n_ovf + 1;
    end
    // Wide enough that no flag at the top of a packed compare is cut away.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Control write held for exactly one taking edge; outputs read 1 ns later.
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] s, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        sel <= s;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic do_sleep();
        @(posedge clk);
        sleep <= 1'b1;
        @(posedge clk);
        sleep <= 1'b0;
        #1;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        check({halt, to_f, pd_f}, 3'b011);
        check(pend, PDW_PEND_RST);
        i_pins.flip(0, 1);
        repeat (10) @(posedge clk);
        check(pend, 8'h01);
        check(n_irq, 0);
        $display("test reset done");
    endtask
    task automatic t_config();
        wr_reg(PDW_CTRL_PORTB, PDW_SEL_EDGE, 8'h2e);
        wr_reg(PDW_CTRL_PORTB, PDW_SEL_PEND, 8'h00);
        check({w_ld, w_o, pend}, {1'b1, 8'h01, 8'h00});
        wr_reg(PDW_CTRL_PORTB, PDW_SEL_EN, 8'hf0);
        i_pins.flip(0, 1);
        repeat (10) @(posedge clk);
        check({pend, 8'(n_irq)}, {8'h01, 8'h01});
        i_pins.flip(1, 1);
        i_pins.flip(4, 0);
        i_pins.flip(5, 0);
        repeat (10) @(posedge clk);
        check({pend, 8'(n_irq)}, {8'h13, 8'h02});
        wr_reg(3'h5, PDW_SEL_PEND, 8'h00);
        check({w_ld, pend}, {1'b0, 8'h13});
        wr_reg(PDW_CTRL_PORTB, PDW_SEL_PEND, 8'h00);
        check({w_ld, w_o}, {1'b1, 8'h13});
        $display("test config done");
    endtask
    // A low clock enable freezes the pin chain too, so the edge waits for it.
    task automatic t_freeze();
        @(posedge clk);
        ce <= 1'b0;
        i_pins.flip(3, 1);
        repeat (10) @(posedge clk);
        check({pend, 8'(n_irq)}, {8'h00, 8'h02});
        ce <= 1'b1;
        repeat (10) @(posedge clk);
        check({pend, 8'(n_irq)}, {8'h08, 8'h03});
        $display("test clock enable done");
    endtask
    task automatic t_sleep_pin();
        base = n_irq;
        do_sleep();
        check({halt, to_f, pd_f}, 3'b111);
        i_pins.flip(4, 5);
        repeat (10) @(posedge clk);
        check(halt, 1'b1);
        i_pins.flip(2, 3);
        for (int i = 0; i < 20 && halt === 1'b1; i++) @(posedge clk);
        repeat (3) @(posedge clk);
        check({halt, pc, 8'(n_pcld)}, {1'b0, PDW_RESET_PC, 8'h01});
        check(n_irq, base);
        $display("test pin wake done");
    endtask
    // The early clear must push the first overflow past the sleep strobe.
    task automatic t_wdt();
        @(posedge clk);
        wdt_en <= 1'b1;
        repeat (10) @(posedge clk);
        wdt_clr <= 1'b1;
        @(posedge clk);
        wdt_clr <= 1'b0;
        repeat (8) @(posedge clk);
        sleep <= 1'b1;
        @(posedge clk);
        sleep <= 1'b0;
        #1;
        check(n_ovf, 0);
        check({halt, to_f, pd_f}, 3'b110);
        repeat ((1 << WDT_W) - 1) @(posedge clk);
        #1;
        check(halt, 1'b1);
        @(posedge clk);
        #1;
        check({halt, ovf, to_f}, 3'b010);
        @(posedge clk);
        wdt_en <= 1'b0;
        #1;
        check({8'(n_ovf), pc_ld, pc}, {8'h01, 1'b1, PDW_RESET_PC});
        repeat (3) @(posedge clk);
        $display("test watchdog wake done");
    endtask
    task automatic t_ext();
        do_sleep();
        check(halt, 1'b1);
        @(posedge clk);
        ext_n <= 1'b0;
        repeat (10) @(posedge clk);
        check({halt, to_f, pd_f, pend}, {3'b011, 8'h00});
        ext_n <= 1'b1;
        repeat (8) @(posedge clk);
        base = n_irq;
        i_pins.flip(0, 1);
        repeat (10) @(posedge clk);
        check({pend, 8'(n_irq - base)}, {8'h01, 8'h00});
        $display("test external reset done");
    endtask

    // Main sequence and the watchdog against a hang.
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset();
        t_config();
        t_freeze();
        t_sleep_pin();
        t_wdt();
        t_ext();
        stop_test();
    end
    initial begin
        #50000;
        n_mismatch++;
        $display("run took too long");
        stop_test();
    end
endmodule
